// ### drive_master_slave_follower_test.sv
// Purpose: Self-checking bench for the speed follower
// Assumes: Bus answers with zero wait states
// Notes: Frame period shortened to 200 cycles
`timescale 1ns/1ps
`include "msf_regs.vh"
module drive_master_slave_follower_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic [15:0] torque = 16'h0000;
   logic [15:0] rated_torque = 16'h0064;
   logic [31:0] rd;
   wire hready, hresp, rx_valid, rx_err, tx_valid, tx_ready, run_out;
   wire [31:0] hrdata;
   wire [7:0] rx_data, tx_data;
   wire [15:0] out_freq;
   wire [5:0] modbus_address;
   int n_fail = 0;
   int compares = 0;
   always #2 clk = ~clk;
   msf_follower #(.FRAME_CYCLES(200)) dut_u (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .actual_torque(torque),
      .motor_rated_torque(rated_torque), .run_out(run_out), .out_freq(out_freq),
      .modbus_address(modbus_address));
   msf_peer peer_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
   task automatic give_verdict;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One single transfer; read data lands in rd
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic outs(input logic run, input logic [15:0] f);
      repeat (4) @(posedge clk);
      chk({15'h0, run_out, out_freq}, {15'h0, run, f});
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rchk(`MSF_ADDR_CTRL, 32'h0);
      rchk(`MSF_ADDR_SCALE, 32'h3E8);
      rchk(`MSF_ADDR_DROOP, 32'h0);
      rchk(`MSF_ADDR_RATED, 32'h1F4);
      rchk(8'h20, 32'h0);
      ahb(1'b1, `MSF_ADDR_CTRL, 32'h2);
      @(posedge clk);
      chk({26'h0, modbus_address}, 32'h2);
      peer_u.send_frame(8'h01, 1'b1, 16'h01F4, 1'b0, 1'b0);
      outs(1'b1, 16'h01F4);
      rchk(`MSF_ADDR_RXF, 32'h000101F4);
      peer_u.send_frame(8'h01, 1'b0, 16'h0100, 1'b1, 1'b0);
      outs(1'b1, 16'h01F4);
      peer_u.send_frame(8'h01, 1'b0, 16'h0100, 1'b0, 1'b1);
      outs(1'b1, 16'h01F4);
      peer_u.send_frame(8'h02, 1'b0, 16'h0100, 1'b0, 1'b0);
      outs(1'b1, 16'h01F4);
      peer_u.send_frame(8'h01, 1'b0, 16'h0100, 1'b0, 1'b0);
      outs(1'b0, 16'h0100);
      peer_u.send_frame(8'h01, 1'b1, 16'h01F4, 1'b0, 1'b0);
      ahb(1'b1, `MSF_ADDR_CTRL, 32'h1002);
      ahb(1'b1, `MSF_ADDR_SCALE, 32'h1F4);
      outs(1'b1, 16'h00FA);
      ahb(1'b1, `MSF_ADDR_SCALE, 32'h3E8);
      outs(1'b1, 16'h01F4);
      // Same droop on every drive that shares the load
      ahb(1'b1, `MSF_ADDR_CTRL, 32'h2);
      ahb(1'b1, `MSF_ADDR_DROOP, 32'h32);
      torque <= 16'h0064;
      outs(1'b1, 16'h01DB);
      torque <= 16'h0032;
      outs(1'b1, 16'h01E8);
      rated_torque <= 16'h00C8;
      outs(1'b1, 16'h01EE);
      torque <= 16'h0000;
      rated_torque <= 16'h0064;
      outs(1'b1, 16'h01F4);
      torque <= 16'h0064;
      ahb(1'b1, `MSF_ADDR_CTRL, 32'h10002);
      outs(1'b1, 16'h01F4);
      ahb(1'b1, `MSF_ADDR_CTRL, 32'h2);
      ahb(1'b1, `MSF_ADDR_DROOP, 32'h3E8);
      torque <= 16'h00C8;
      outs(1'b1, 16'h0000);
      torque <= 16'h0000;
      ahb(1'b1, `MSF_ADDR_DROOP, 32'h0);
      ahb(1'b1, `MSF_ADDR_CTRL, 32'h1);
      peer_u.send_frame(8'h01, 1'b1, 16'h0200, 1'b0, 1'b0);
      outs(1'b0, 16'h01F4);
      rchk(`MSF_ADDR_RXF, 32'h000101F4);
      rchk(`MSF_ADDR_STATUS, 32'h00040308);
      // Master at station 1; receiver stall ends before the first master frame is sent
      peer_u.hold <= 1'b1;
      ahb(1'b1, `MSF_ADDR_LOCAL, 32'h01230001);
      ahb(1'b1, `MSF_ADDR_CTRL, 32'h101);
      outs(1'b1, 16'h0123);
      rchk(`MSF_ADDR_OUTF, 32'h00000123);
      repeat (30) @(posedge clk);
      peer_u.hold <= 1'b0;
      repeat (2000) if (peer_u.n_cap < 18) @(posedge clk);
      chk({peer_u.cap[6], peer_u.cap[7], peer_u.cap[8], peer_u.cap[9]}, 32'hA5010101);
      chk({16'h0, peer_u.cap[10], peer_u.cap[11]}, 32'h00002322);
      chk(32'(peer_u.sync_t[2] - peer_u.sync_t[1]), 32'h00000320);
      give_verdict;
   end
   initial begin
      #(20000 * 4);
      n_fail++;
      give_verdict;
   end
endmodule

// ### msf_buf2.v
// Purpose: Two-entry valid/ready buffer in the transmit byte path
// Assumes: Single clock, asynchronous active-high reset
// Notes: Output data comes straight from the head flip-flop
`timescale 1ns/1ps
module msf_buf2 #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] slot1;
   reg [1:0] count;
   wire push;
   wire pop;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_data <= {WIDTH{1'b0}};
         slot1 <= {WIDTH{1'b0}};
         count <= 2'h0;
      end else begin
         if (push && pop) begin
            if (count == 2'h1) begin
               out_data <= in_data;
            end else begin
               out_data <= slot1;
               slot1 <= in_data;
            end
         end else if (pop) begin
            out_data <= slot1;
            count <= count - 2'h1;
         end else if (push) begin
            if (count == 2'h0) begin
               out_data <= in_data;
            end else begin
               slot1 <= in_data;
            end
            count <= count + 2'h1;
         end
      end
   end

endmodule

// ### msf_follower.v
// Purpose: Networked master/slave speed following with speed droop load sharing
// Assumes: Byte streams to and from the RS485 transceiver logic, AHB-Lite register access
// Notes: Frame is sync, source address, run flag, freq high, freq low, xor check
//
// Functional notes
// - Network holds at most 64 drives; station address is six bits.
// - Master sends run state and output frequency every 30 ms.
// - Slave runs or stops following the latest master run state.
// - Slave uses received master frequency as its setpoint before scaling.
// - Slave addresses limited to 0 or 2 to 63, up to 63 slaves.
// - Station address also serves as Modbus and tool address.
// - Scaling source 0: slave runs exactly at master frequency.
// - Scaling source 1: slave frequency is master frequency times scaling factor.
// - Droop applies only when vector control select equals 0.
// - At rated full load frequency drops by droop percent of rated frequency.
// - Output equals setpoint minus droop times rated freq times torque over rated torque.
// - No load gives the setpoint; reduction grows linearly with load.
`timescale 1ns/1ps
`include "msf_regs.vh"
module msf_follower #(
   parameter FRAME_CYCLES = `MSF_FRAME_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // AHB-Lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Network receive bytes
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire rx_err,
   // Network transmit bytes
   output wire tx_valid,
   input wire tx_ready,
   output wire [7:0] tx_data,
   // Motor torque feedback
   input wire [15:0] actual_torque,
   input wire [15:0] motor_rated_torque,
   // Drive control outputs
   output reg run_out,
   output reg [15:0] out_freq,
   output wire [5:0] modbus_address
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // A master must sit at address 1; a slave may use anything else
   function addr_ok;
      input [5:0] addr;
      input master;
      begin
         addr_ok = master ? (addr == `MSF_MASTER_ADDR) : (addr != `MSF_MASTER_ADDR);
      end
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [5:0] network_station_address;
   reg master_role_select;
   reg slave_scaling_source;
   reg [1:0] vector_control_select;
   reg [15:0] slave_scaling_factor;
   reg [9:0] droop_percentage;
   reg [15:0] motor_rated_frequency;
   reg local_run;
   reg [15:0] local_freq;
   reg rx_run;
   reg [15:0] rx_freq;
   reg frame_seen;
   reg [7:0] good_count;
   reg [7:0] bad_count;

   reg dp_write;
   reg [7:0] dp_addr;
   wire ap_valid;
   wire is_master;
   wire station_ok;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ap_valid = hsel & hready & htrans[1];
   assign is_master = master_role_select;
   assign station_ok = addr_ok(network_station_address, master_role_select);
   assign modbus_address = network_station_address;

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   // Zero wait states: read data is captured at the address phase edge
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         dp_write <= ap_valid & hwrite;
         if (ap_valid) begin
            dp_addr <= {haddr[7:2], 2'b00};
         end
         if (ap_valid && !hwrite) begin
            case ({haddr[7:2], 2'b00})
               `MSF_ADDR_CTRL: hrdata <= {14'h0000, vector_control_select, 3'h0, slave_scaling_source,
                  3'h0, master_role_select, 2'h0, network_station_address};
               `MSF_ADDR_SCALE: hrdata <= {16'h0000, slave_scaling_factor};
               `MSF_ADDR_DROOP: hrdata <= {22'h000000, droop_percentage};
               `MSF_ADDR_RATED: hrdata <= {16'h0000, motor_rated_frequency};
               `MSF_ADDR_LOCAL: hrdata <= {local_freq, 15'h0000, local_run};
               `MSF_ADDR_STATUS: hrdata <= {8'h00, bad_count, good_count, 4'h0, frame_seen,
                  station_ok, is_master, run_out};
               `MSF_ADDR_OUTF: hrdata <= {16'h0000, out_freq};
               `MSF_ADDR_RXF: hrdata <= {15'h0000, rx_run, rx_freq};
               default: hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         network_station_address <= `MSF_RST_ADDR;
         master_role_select <= 1'b0;
         slave_scaling_source <= 1'b0;
         vector_control_select <= `MSF_VCS_SPEED;
         slave_scaling_factor <= `MSF_RST_SCALE;
         droop_percentage <= `MSF_RST_DROOP;
         motor_rated_frequency <= `MSF_RST_RATED;
         local_run <= 1'b0;
         local_freq <= `MSF_RST_FREQ;
      end else if (dp_write) begin
         case (dp_addr)
            `MSF_ADDR_CTRL: begin
               network_station_address <= hwdata[`MSF_CTRL_ADDR_MSB:`MSF_CTRL_ADDR_LSB];
               master_role_select <= hwdata[`MSF_CTRL_MASTER_BIT];
               slave_scaling_source <= hwdata[`MSF_CTRL_SRC_BIT];
               vector_control_select <= hwdata[`MSF_CTRL_VCS_MSB:`MSF_CTRL_VCS_LSB];
            end
            `MSF_ADDR_SCALE: slave_scaling_factor <= hwdata[15:0];
            `MSF_ADDR_DROOP: droop_percentage <= hwdata[9:0];
            `MSF_ADDR_RATED: motor_rated_frequency <= hwdata[15:0];
            `MSF_ADDR_LOCAL: begin
               local_run <= hwdata[`MSF_LOCAL_RUN_BIT];
               local_freq <= hwdata[`MSF_LOCAL_FREQ_MSB:`MSF_LOCAL_FREQ_LSB];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Frame receiver
   // ----------------------------------------
   reg [2:0] rx_idx;
   reg [5:0] rx_src;
   reg rx_src_hi;
   reg rx_stat;
   reg [7:0] rx_fhi;
   reg [7:0] rx_chk;
   reg [7:0] rx_flo;
   wire rx_frame_good;

   // Frames from anything but address 1, or arriving while we are master, are dropped
   assign rx_frame_good = (rx_data == rx_chk) && !rx_src_hi && (rx_src == `MSF_MASTER_ADDR) &&
      !is_master && station_ok;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_idx <= 3'h0;
         rx_src <= 6'h00;
         rx_src_hi <= 1'b0;
         rx_stat <= 1'b0;
         rx_fhi <= 8'h00;
         rx_chk <= 8'h00;
         rx_flo <= 8'h00;
         rx_run <= 1'b0;
         rx_freq <= `MSF_RST_FREQ;
         frame_seen <= 1'b0;
         good_count <= 8'h00;
         bad_count <= 8'h00;
      end else if (rx_err) begin
         if (rx_idx != 3'h0) begin
            bad_count <= bad_count + 8'h01;
         end
         rx_idx <= 3'h0;
      end else if (rx_valid) begin
         case (rx_idx)
            3'h0: begin
               if (rx_data == `MSF_SYNC_BYTE) begin
                  rx_idx <= 3'h1;
               end
            end
            3'h1: begin
               rx_src <= rx_data[5:0];
               rx_src_hi <= |rx_data[7:6];
               rx_chk <= rx_data;
               rx_idx <= 3'h2;
            end
            3'h2: begin
               rx_stat <= rx_data[0];
               rx_chk <= rx_chk ^ rx_data;
               rx_idx <= 3'h3;
            end
            3'h3: begin
               rx_fhi <= rx_data;
               rx_chk <= rx_chk ^ rx_data;
               rx_idx <= 3'h4;
            end
            3'h4: begin
               // Low byte is held apart so the setpoint only moves on the check byte
               rx_flo <= rx_data;
               rx_chk <= rx_chk ^ rx_data;
               rx_idx <= `MSF_FRAME_LAST;
            end
            `MSF_FRAME_LAST: begin
               rx_idx <= 3'h0;
               if (rx_frame_good) begin
                  rx_run <= rx_stat;
                  rx_freq <= {rx_fhi, rx_flo};
                  frame_seen <= 1'b1;
                  good_count <= good_count + 8'h01;
               end else begin
                  bad_count <= bad_count + 8'h01;
               end
            end
            default: rx_idx <= 3'h0;
         endcase
      end
   end

   // ----------------------------------------
   // Setpoint, scaling and droop
   // ----------------------------------------
   reg [15:0] setpoint;
   reg [31:0] scale_prod;
   reg [31:0] scale_quot;
   reg [15:0] scaled;
   reg [41:0] droop_num;
   reg [25:0] droop_den;
   reg [41:0] droop_red;
   reg [15:0] next_out_freq;
   reg next_run_out;

   // Wide combinational divide; fine at this rate only if timing is relaxed by multicycle paths
   always @* begin
      setpoint = is_master ? local_freq : rx_freq;
      scale_prod = setpoint * slave_scaling_factor;
      scale_quot = scale_prod / `MSF_PCT_FULL;
      if (!is_master && slave_scaling_source) begin
         scaled = (scale_quot[31:16] != 16'h0000) ? 16'hFFFF : scale_quot[15:0];
      end else begin
         scaled = setpoint;
      end
      droop_num = droop_percentage * motor_rated_frequency * actual_torque;
      droop_den = motor_rated_torque * 10'h3E8;
      droop_red = 42'h0;
      if ((vector_control_select == `MSF_VCS_SPEED) && (droop_den != 26'h0)) begin
         droop_red = droop_num / droop_den;
      end
      if (droop_red >= {26'h0, scaled}) begin
         next_out_freq = 16'h0000;
      end else begin
         next_out_freq = scaled - droop_red[15:0];
      end
      next_run_out = station_ok & (is_master ? local_run : rx_run);
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_freq <= `MSF_RST_FREQ;
         run_out <= 1'b0;
      end else begin
         out_freq <= next_out_freq;
         run_out <= next_run_out;
      end
   end

   // ----------------------------------------
   // Master broadcast
   // ----------------------------------------
   localparam T_IDLE = 1'b0;
   localparam T_SEND = 1'b1;

   reg tx_state;
   reg [2:0] tx_idx;
   reg [31:0] period_cnt;
   reg snap_run;
   reg [15:0] snap_freq;
   reg [7:0] snap_chk;
   reg [7:0] push_data;
   wire push_ready;
   wire period_tick;
   wire push_valid;

   assign period_tick = (period_cnt == FRAME_CYCLES - 1);
   assign push_valid = (tx_state == T_SEND);

   always @* begin
      case (tx_idx)
         3'h0: push_data = `MSF_SYNC_BYTE;
         3'h1: push_data = {2'b00, `MSF_MASTER_ADDR};
         3'h2: push_data = {7'h00, snap_run};
         3'h3: push_data = snap_freq[15:8];
         3'h4: push_data = snap_freq[7:0];
         default: push_data = snap_chk;
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         period_cnt <= 32'h00000000;
         tx_state <= T_IDLE;
         tx_idx <= 3'h0;
         snap_run <= 1'b0;
         snap_freq <= `MSF_RST_FREQ;
         snap_chk <= 8'h00;
      end else begin
         period_cnt <= period_tick ? 32'h00000000 : period_cnt + 32'h00000001;
         case (tx_state)
            T_IDLE: begin
               // A late frame is skipped rather than queued, so the beat stays at one period
               if (period_tick && is_master && station_ok) begin
                  snap_run <= run_out;
                  snap_freq <= out_freq;
                  snap_chk <= {2'b00, `MSF_MASTER_ADDR} ^ {7'h00, run_out} ^ out_freq[15:8] ^ out_freq[7:0];
                  tx_idx <= 3'h0;
                  tx_state <= T_SEND;
               end
            end
            T_SEND: begin
               if (push_ready) begin
                  if (tx_idx == `MSF_FRAME_LAST) begin
                     tx_state <= T_IDLE;
                  end
                  tx_idx <= tx_idx + 3'h1;
               end
            end
            default: tx_state <= T_IDLE;
         endcase
      end
   end

   msf_buf2 #(
      .WIDTH(8)
   ) u_txbuf (
      .clk(clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );

endmodule

// ### msf_follower_asserts.sv
// Purpose: Port-level checks for the speed follower
// Assumes: Bound into msf_follower, one clock domain
// Notes: Output moves must trace back to bus, link or torque activity
`timescale 1ns/1ps
`include "msf_regs.vh"
module msf_follower_asserts #(
   parameter FRAME_CYCLES = 200
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Bus
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hreadyout,
   input wire hresp,
   // Link
   input wire rx_valid,
   input wire tx_valid,
   input wire tx_ready,
   input wire [7:0] tx_data,
   // Drive
   input wire [15:0] actual_torque,
   input wire [15:0] motor_rated_torque,
   input wire run_out,
   input wire [15:0] out_freq,
   input wire [5:0] modbus_address
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire wr_ap = hsel && htrans[1] && hwrite;
   wire tx_hs = tx_valid && tx_ready;
   reg [3:0] quiet;
   reg [2:0] tx_idx;
   reg [7:0] tx_x;
   // ----------------------------------------
   // Activity age and frame position
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         quiet <= 4'hF;
         tx_idx <= 3'h0;
         tx_x <= 8'h00;
      end else begin
         if (rx_valid || wr_ap || $changed(actual_torque) || $changed(motor_rated_torque))
            quiet <= 4'h0;
         else if (quiet != 4'hF)
            quiet <= quiet + 4'h1;
         if (tx_hs) begin
            tx_idx <= (tx_idx == 3'h5) ? 3'h0 : tx_idx + 3'h1;
            tx_x <= (tx_idx == 3'h1) ? tx_data : tx_x ^ tx_data;
         end
      end
   end
   sequence s_stalled;
      tx_valid && !tx_ready;
   endsequence
   sequence s_held;
      tx_valid && $stable(tx_data);
   endsequence
   AST_BUS_READY: assert property (hreadyout)
      else $error("bus wait state inserted");
   AST_BUS_OKAY: assert property (hsel |=> !hresp)
      else $error("bus error response");
   AST_TX_HOLD: assert property (s_stalled |=> s_held)
      else $error("tx byte changed while stalled");
   AST_TX_SYNC: assert property (tx_hs && tx_idx == 3'h0 |-> tx_data == `MSF_SYNC_BYTE)
      else $error("frame does not open with sync");
   AST_TX_SRC: assert property (tx_hs && tx_idx == 3'h1 |-> tx_data == {2'b00, `MSF_MASTER_ADDR})
      else $error("master frame source not station 1");
   AST_TX_CHECK: assert property (tx_hs && tx_idx == 3'h5 |-> tx_data == tx_x)
      else $error("frame check byte wrong");
   AST_RUN_CAUSE: assert property ($rose(run_out) |-> quiet < 4'h6)
      else $error("run started without cause");
   AST_FREQ_CAUSE: assert property ($changed(out_freq) |-> quiet < 4'h6)
      else $error("frequency moved without cause");
   AST_MODBUS: assert property ($changed(modbus_address) |-> $past(wr_ap && haddr[7:2] == 6'h00, 2))
      else $error("modbus address moved without control write");
endmodule
bind msf_follower msf_follower_asserts #(.FRAME_CYCLES(FRAME_CYCLES)) chk_u (
   .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_data(tx_data), .actual_torque(actual_torque),
   .motor_rated_torque(motor_rated_torque), .run_out(run_out), .out_freq(out_freq),
   .modbus_address(modbus_address));

// ### msf_peer.sv
// Purpose: Model of the other drives on the network
// Assumes: Byte-level link, one clock
// Notes: Receiver stalls every other cycle, longer while hold is set
`timescale 1ns/1ps
module msf_peer (
   // Clock
   input wire logic clk,
   // Bytes into the block
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_err,
   // Bytes out of the block
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data
);
   logic hold = 1'b0;
   logic ph = 1'b0;
   logic [7:0] cap [0:31];
   time sync_t [0:7];
   int n_cap = 0;
   int n_sync = 0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_err = 1'b0;
      tx_ready = 1'b0;
   end
   always @(posedge clk) begin
      ph <= ~ph;
      tx_ready <= ph & ~hold;
      if (tx_valid && tx_ready) begin
         if (n_cap % 6 == 0 && n_sync < 8) begin
            sync_t[n_sync] <= $time;
            n_sync <= n_sync + 1;
         end
         if (n_cap < 32)
            cap[n_cap] <= tx_data;
         n_cap <= n_cap + 1;
      end
   end
   // Idle data line shows the inverse so a stale byte is never reused
   task automatic send_byte(input logic [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~b;
   endtask
   // Only the station-1 master sends on a healthy net
   task automatic send_frame(input logic [7:0] src, input logic run, input logic [15:0] freq,
                             input logic bad, input logic abort);
      logic [7:0] b [0:5];
      b[0] = 8'hA5;
      b[1] = src;
      b[2] = {7'h00, run};
      b[3] = freq[15:8];
      b[4] = freq[7:0];
      b[5] = src ^ b[2] ^ b[3] ^ b[4] ^ {7'h00, bad};
      for (int i = 0; i < 6; i++) begin
         if (abort && i == 3) begin
            @(posedge clk);
            rx_err <= 1'b1;
            @(posedge clk);
            rx_err <= 1'b0;
         end
         send_byte(b[i]);
      end
   endtask
endmodule

// ### msf_regs.vh
// Purpose: Constants for the master/slave speed follower with droop
// Assumes: 32-bit AHB-Lite register words, 250 MHz core clock
// Notes: Frequencies in 0.1 Hz units, percentages in 0.1 % units
`ifndef MSF_REGS_VH
`define MSF_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MSF_ADDR_CTRL 8'h00
`define MSF_ADDR_SCALE 8'h04
`define MSF_ADDR_DROOP 8'h08
`define MSF_ADDR_RATED 8'h0C
`define MSF_ADDR_LOCAL 8'h10
`define MSF_ADDR_STATUS 8'h14
`define MSF_ADDR_OUTF 8'h18
`define MSF_ADDR_RXF 8'h1C

// ----------------------------------------
// Control and local register fields
// ----------------------------------------
`define MSF_CTRL_ADDR_LSB 0
`define MSF_CTRL_ADDR_MSB 5
`define MSF_CTRL_MASTER_BIT 8
`define MSF_CTRL_SRC_BIT 12
`define MSF_CTRL_VCS_LSB 16
`define MSF_CTRL_VCS_MSB 17
`define MSF_LOCAL_RUN_BIT 0
`define MSF_LOCAL_FREQ_LSB 16
`define MSF_LOCAL_FREQ_MSB 31

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MSF_RST_ADDR 6'h00
`define MSF_RST_SCALE 16'h03E8
`define MSF_RST_DROOP 10'h000
`define MSF_RST_RATED 16'h01F4
`define MSF_RST_FREQ 16'h0000

// ----------------------------------------
// Network constants
// ----------------------------------------
`define MSF_MASTER_ADDR 6'h01
`define MSF_SYNC_BYTE 8'hA5
`define MSF_FRAME_LAST 3'h5
`define MSF_PCT_FULL 32'h000003E8
`define MSF_VCS_SPEED 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define MSF_FRAME_PERIOD_MS 30
`define MSF_CLK_MHZ 250
`define MSF_FRAME_CYCLES (`MSF_FRAME_PERIOD_MS * 1000 * `MSF_CLK_MHZ)

`endif
